// ==== core/cwrbs_pkg.sv ====
// Constants for the cold/warm reset and boot-select sequencer
// Behaviour
// - Select high: boot vector from external value
// - Select low: boot vector from on-chip storage
// - Cold reset input starts cold reset sequence
// - Cold reset waits for multiplier lock
// - Warm line assertion starts warm reset
// - Drive warm line while warm reset runs
// - Processor clock integer multiple of master
// - Output bus clock for peripheral bus
package cwrbs_pkg;
  // --------------------------------------------------------------
  // Vector layout
  // --------------------------------------------------------------
  localparam int BOOT_VEC_W = 32;
  localparam int MULT_LSB = 0;
  localparam int MULT_W = 4;
  localparam logic [BOOT_VEC_W-1:0] BOOT_VEC_RST = 32'h0000_0000;
  localparam logic [MULT_W-1:0] MULT_RST = 4'h1;
  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PLL_LOCK_NS = 100000;
  localparam int PLL_LOCK_CYC_DFLT = (PLL_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WARM_HOLD_NS = 2000;
  localparam int WARM_HOLD_CYC = (WARM_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WARM_GUARD_CYC = 4;
  localparam int CNT_W = 16;
  // --------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {ST_COLD, ST_LOCK, ST_BOOT, ST_RUN, ST_WARM} cwrbs_state_t;

  function automatic logic [CNT_W-1:0] satDec(input logic [CNT_W-1:0] v);
    satDec = (v == '0) ? v : v - 16'h0001;
  endfunction : satDec
endpackage : cwrbs_pkg

// ==== core/cwrbs_pll_if.sv ====
// Handshake between sequencer and clock multiplier model
`timescale 1ns/1ps
interface cwrbs_pll_if;
  logic lockStart;
  logic locked;
  logic busClk;
  modport seq (output lockStart, input locked, input busClk);
  modport pll (input lockStart, output locked, output busClk);
endinterface : cwrbs_pll_if

// ==== core/cwrbs_pll_lock.sv ====
// Clock multiplier lock timer and bus clock divider
`timescale 1ns/1ps
module cwrbs_pll_lock
  import cwrbs_pkg::*;
#(
  parameter int LOCK_CYC = PLL_LOCK_CYC_DFLT
)
(
  input wire logic core_clk,
  input wire logic rst,
  cwrbs_pll_if.pll pllIf
);
  logic [CNT_W-1:0] lockCnt_q;
  logic counting_q;
  logic locked_q;
  logic busClk_q;
  wire logic lockDone = counting_q && (lockCnt_q == 16'h0000);

  assign pllIf.locked = locked_q;
  assign pllIf.busClk = busClk_q;

  // --------------------------------------------------------------
  // Lock timer
  // --------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || pllIf.lockStart)
    begin
      lockCnt_q <= CNT_W'(LOCK_CYC - 1);
      counting_q <= !rst;
      locked_q <= 1'b0;
    end
    else
    begin
      lockCnt_q <= satDec(lockCnt_q);
      counting_q <= counting_q && !lockDone;
      locked_q <= locked_q || lockDone;
    end
  end

  // Bus clock runs from the master clock, independent of lock state
  always_ff @(posedge core_clk)
  begin
    if (rst)
      busClk_q <= 1'b0;
    else
      busClk_q <= !busClk_q;
  end
endmodule : cwrbs_pll_lock

// ==== core/cwrbs_top.sv ====
// Cold/warm reset sequencer with boot vector source selection
`timescale 1ns/1ps
module cwrbs_top
  import cwrbs_pkg::*;
#(
  parameter int PLL_LOCK_CYC = PLL_LOCK_CYC_DFLT
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic coldResetN,
  input wire logic bootVectorSourceSelect,
  input wire logic [BOOT_VEC_W-1:0] extBootVector,
  input wire logic [BOOT_VEC_W-1:0] nvramBootVector,
  input wire logic softWarmReq,
  input wire logic warmResetLineNIn,
  output logic warmResetLineNOut,
  output logic warmResetLineNOe,
  output logic busClockOut,
  output logic coreResetActive,
  output logic coldResetActive,
  output logic warmResetActive,
  output logic bootVectorFromExt,
  output logic [BOOT_VEC_W-1:0] bootVector,
  output logic [MULT_W-1:0] cpuClkMult,
  output logic pllLocked
);
  cwrbs_pll_if pllIf ();

  cwrbs_pll_lock #(.LOCK_CYC(PLL_LOCK_CYC)) uPll (
    .core_clk(core_clk),
    .rst(rst),
    .pllIf(pllIf)
  );

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  logic cold0_q;
  logic cold1_q;
  logic warm0_q;
  logic warm1_q;

  // Reset values assume a held cold reset so power-up runs the cold flow
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cold0_q <= 1'b0;
      cold1_q <= 1'b0;
      warm0_q <= 1'b1;
      warm1_q <= 1'b1;
    end
    else
    begin
      cold0_q <= coldResetN;
      cold1_q <= cold0_q;
      warm0_q <= warmResetLineNIn;
      warm1_q <= warm0_q;
    end
  end

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  cwrbs_state_t st_q;
  cwrbs_state_t st_d;
  logic [CNT_W-1:0] warmCnt_q;
  logic [CNT_W-1:0] guard_q;
  logic warmResetLineNOut_q;
  logic warmResetLineNOe_q;
  logic busClockOut_q;
  logic coreResetActive_q;
  logic coldResetActive_q;
  logic warmResetActive_q;
  logic bootVectorFromExt_q;
  logic [BOOT_VEC_W-1:0] bootVector_q;
  logic [MULT_W-1:0] cpuClkMult_q;
  logic pllLocked_q;

  wire logic coldHeld = !cold1_q;
  // Own drive reads back low, so the guard masks that echo after release
  wire logic lineWarm = !warm1_q && !warmResetLineNOe_q && (guard_q == 16'h0000);
  wire logic warmReq = softWarmReq || lineWarm;
  wire logic [BOOT_VEC_W-1:0] bootPick = bootVectorSourceSelect ? extBootVector : nvramBootVector;
  wire logic bootLoad = (st_q == ST_BOOT);
  wire logic warmEnter = (st_q == ST_RUN) && !coldHeld && warmReq;

  assign pllIf.lockStart = (st_q == ST_COLD) && !coldHeld;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_COLD: if (!coldHeld) st_d = ST_LOCK;
      ST_LOCK:
      begin
        if (coldHeld)
          st_d = ST_COLD;
        else if (pllIf.locked)
          st_d = ST_BOOT;
      end
      ST_BOOT: st_d = coldHeld ? ST_COLD : ST_RUN;
      ST_RUN:
      begin
        if (coldHeld)
          st_d = ST_COLD;
        else if (warmReq)
          st_d = ST_WARM;
      end
      ST_WARM:
      begin
        if (coldHeld)
          st_d = ST_COLD;
        else if (warmCnt_q == 16'h0000)
          st_d = ST_RUN;
      end
      default: st_d = ST_COLD;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_q <= ST_COLD;
    else
      st_q <= st_d;
  end

  // Warm hold and echo guard counters
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      warmCnt_q <= 16'h0000;
      guard_q <= 16'h0000;
    end
    else
    begin
      warmCnt_q <= warmEnter ? CNT_W'(WARM_HOLD_CYC - 1) : satDec(warmCnt_q);
      guard_q <= (st_q == ST_WARM) ? CNT_W'(WARM_GUARD_CYC) : satDec(guard_q);
    end
  end

  // --------------------------------------------------------------
  // Boot vector capture
  // --------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bootVector_q <= BOOT_VEC_RST;
      bootVectorFromExt_q <= 1'b0;
      cpuClkMult_q <= MULT_RST;
    end
    else if (bootLoad)
    begin
      bootVector_q <= bootPick;
      bootVectorFromExt_q <= bootVectorSourceSelect;
      cpuClkMult_q <= bootPick[MULT_LSB +: MULT_W];
    end
  end

  // --------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      warmResetLineNOut_q <= 1'b0;
      warmResetLineNOe_q <= 1'b0;
      busClockOut_q <= 1'b0;
      coreResetActive_q <= 1'b1;
      coldResetActive_q <= 1'b1;
      warmResetActive_q <= 1'b0;
      pllLocked_q <= 1'b0;
    end
    else
    begin
      warmResetLineNOut_q <= 1'b0;
      warmResetLineNOe_q <= (st_d == ST_WARM);
      busClockOut_q <= pllIf.busClk;
      coreResetActive_q <= (st_d != ST_RUN);
      coldResetActive_q <= (st_d == ST_COLD) || (st_d == ST_LOCK) || (st_d == ST_BOOT);
      warmResetActive_q <= (st_d == ST_WARM);
      pllLocked_q <= pllIf.locked;
    end
  end

  assign warmResetLineNOut = warmResetLineNOut_q;
  assign warmResetLineNOe = warmResetLineNOe_q;
  assign busClockOut = busClockOut_q;
  assign coreResetActive = coreResetActive_q;
  assign coldResetActive = coldResetActive_q;
  assign warmResetActive = warmResetActive_q;
  assign bootVectorFromExt = bootVectorFromExt_q;
  assign bootVector = bootVector_q;
  assign cpuClkMult = cpuClkMult_q;
  assign pllLocked = pllLocked_q;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_ext_boot_load: assert property (@(posedge core_clk) disable iff (rst)
    bootLoad && bootVectorSourceSelect |=> bootVector_q == $past(extBootVector) && bootVectorFromExt_q)
    else $error("external boot vector not loaded");

  a_nvram_boot_load: assert property (@(posedge core_clk) disable iff (rst)
    bootLoad && !bootVectorSourceSelect |=> bootVector_q == $past(nvramBootVector) && !bootVectorFromExt_q)
    else $error("stored boot vector not loaded");

  a_cold_start_hold: assert property (@(posedge core_clk) disable iff (rst)
    $fell(cold1_q) |=> coldResetActive_q && coreResetActive_q)
    else $error("cold reset not started");

  a_lock_before_boot: assert property (@(posedge core_clk) disable iff (rst)
    (st_q == ST_LOCK) && !pllIf.locked |=> st_q != ST_BOOT && st_q != ST_RUN)
    else $error("left cold reset before lock");

  a_warm_line_start: assert property (@(posedge core_clk) disable iff (rst)
    warmEnter |=> warmResetActive_q && warmResetLineNOe_q)
    else $error("warm reset not started on request");

  a_warm_drive_hold: assert property (@(posedge core_clk) disable iff (rst)
    $rose(warmResetActive_q) |-> (warmResetLineNOe_q && !warmResetLineNOut_q)[*8])
    else $error("warm line not driven during warm reset");

  a_mult_from_vec: assert property (@(posedge core_clk) disable iff (rst)
    bootLoad |=> cpuClkMult_q == ($past(bootVectorSourceSelect) ?
      $past(extBootVector[MULT_LSB +: MULT_W]) : $past(nvramBootVector[MULT_LSB +: MULT_W])))
    else $error("multiplier not taken from boot vector");

  a_bus_clock_run: assert property (@(posedge core_clk) disable iff (rst)
    !$past(rst) ##1 !$past(rst) |-> busClockOut_q != $past(busClockOut_q))
    else $error("bus clock stalled");

  a_cold_sync_release: assert property (@(posedge core_clk) disable iff (rst)
    !coldResetN ##1 coldResetN [*3] |-> cold1_q && !$past(cold1_q))
    else $error("cold release not two-stage synchronised");
endmodule : cwrbs_top

// ==== verif/cwrbs_board_model.sv ====
// Board-side reset logic: cold reset driver and open-drain warm reset wire
`timescale 1ns/1ps
module cwrbs_board_model (
  input wire logic coldReq,
  input wire logic warmReq,
  input wire logic devOe,
  input wire logic devOut,
  output logic coldResetN,
  output logic warmLineN
);
  // ------------------------------------------------------------
  // Cold reset pin, held low while the board asks for it
  // ------------------------------------------------------------
  assign coldResetN = !coldReq;
  // ------------------------------------------------------------
  // Warm wire: pull-up, so a released wire reads high
  // ------------------------------------------------------------
  assign warmLineN = !((devOe && !devOut) || warmReq);
endmodule : cwrbs_board_model

// ==== verif/tb.sv ====
// Self-checking testbench for the cold/warm reset sequencer
`timescale 1ns/1ps
module tb
  import cwrbs_pkg::*;
;
  localparam int LOCK = 8;
  logic core_clk, rst, coldReq, warmReq, sel, softWarmReq;
  logic [31:0] extVec, nvVec, bootVec;
  wire coldResetN, warmLineN;
  logic warmOut, warmOe, busClk, coreAct, coldAct, warmAct, fromExt, locked;
  logic [3:0] mult;
  int fail_count, samples_checked;

  cwrbs_board_model board_u (.coldReq(coldReq), .warmReq(warmReq), .devOe(warmOe),
    .devOut(warmOut), .coldResetN(coldResetN), .warmLineN(warmLineN));

  cwrbs_top #(.PLL_LOCK_CYC(LOCK)) dut_u (.core_clk(core_clk), .rst(rst),
    .coldResetN(coldResetN), .bootVectorSourceSelect(sel), .extBootVector(extVec),
    .nvramBootVector(nvVec), .softWarmReq(softWarmReq), .warmResetLineNIn(warmLineN),
    .warmResetLineNOut(warmOut), .warmResetLineNOe(warmOe), .busClockOut(busClk),
    .coreResetActive(coreAct), .coldResetActive(coldAct), .warmResetActive(warmAct),
    .bootVectorFromExt(fromExt), .bootVector(bootVec), .cpuClkMult(mult),
    .pllLocked(locked));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      fail_count++;
    end
  endtask : check

  function automatic logic pick(input int s);
    return (s == 0) ? coldAct : warmAct;
  endfunction : pick

  // Bounded wait, so a stuck sequencer ends the run
  task automatic waitSig(input int s, input logic v, input int bound, output int n);
    n = 0;
    while (pick(s) !== v && n < bound)
    begin
      @(negedge core_clk);
      n++;
    end
    if (pick(s) !== v)
    begin
      $display("[ERR] %0t wait timed out", $time);
      fail_count++;
      summarize();
    end
  endtask : waitSig

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic testColdBoot(input logic s);
    int n;
    logic [31:0] exp;
    exp = s ? extVec : nvVec;
    coldReq = 1'b1;
    sel = s;
    waitSig(0, 1'b1, 5, n);
    check(coreAct, 1'b1, "core held");
    repeat (4) @(negedge core_clk);
    coldReq = 1'b0;
    waitSig(0, 1'b0, LOCK + 12, n);
    check(n >= LOCK, 1'b1, "left before lock");
    check(locked, 1'b1, "not locked");
    check(bootVec, exp, "vector");
    check(fromExt, s, "source flag");
    check(mult, exp[3:0], "multiplier");
    check(coreAct, 1'b0, "core released");
    $display("test cold boot sel %0b done", s);
  endtask : testColdBoot

  task automatic testBusClock();
    logic prev;
    repeat (4)
    begin
      prev = busClk;
      @(negedge core_clk);
      check(busClk, !prev, "bus clock");
    end
    $display("test bus clock done");
  endtask : testBusClock

  // Cause 0 is the board pulling the wire, 1 the internal request
  task automatic testWarm(input logic cause);
    int n;
    logic [31:0] vec;
    vec = bootVec;
    if (cause)
      softWarmReq = 1'b1;
    else
      warmReq = 1'b1;
    waitSig(1, 1'b1, 6, n);
    softWarmReq = 1'b0;
    warmReq = 1'b0;
    @(negedge core_clk);
    check({warmOe, warmOut, warmLineN, coreAct}, 4'h9, "warm drive");
    waitSig(1, 1'b0, WARM_HOLD_CYC + 4, n);
    check(n, WARM_HOLD_CYC - 1, "warm span");
    check(warmLineN, 1'b1, "wire released");
    check(bootVec, vec, "no reload");
    check(locked, 1'b1, "no relock");
    // The device's own release must not read back as a new request
    repeat (8) @(negedge core_clk);
    check(warmAct, 1'b0, "echo retrigger");
    $display("test warm cause %0b done", cause);
  endtask : testWarm

  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    coldReq = 1'b1;
    warmReq = 1'b0;
    softWarmReq = 1'b0;
    sel = 1'b1;
    extVec = 32'hA5C3_0007;
    nvVec = 32'h1234_567B;
    repeat (8) @(negedge core_clk);
    check({warmAct, warmOe, locked, coreAct, coldAct}, 5'h03, "reset flags");
    check(bootVec, BOOT_VEC_RST, "reset vector");
    check(mult, MULT_RST, "reset multiplier");
    rst = 1'b0;
    testColdBoot(1'b1);
    testBusClock();
    testWarm(1'b0);
    testWarm(1'b1);
    testColdBoot(1'b0);
    testWarm(1'b1);
    summarize();
  end
endmodule : tb
